// >>> dv/cpu_model.sv
// Core and wake source model facing the controller's core side
`timescale 1ns/100ps
module cpu_model
    import pmc_pkg::*;
(
    // Clock
    input  wire logic              clk_i,
    // Bench commands
    input  wire logic              step_i,
    input  wire logic              irq_i,
    input  wire logic [N_WAKE-1:0] wake_i,
    // Core side of the controller
    output logic                   instr_done_o = 1'b0,
    output logic                   irq_pending_o = 1'b0,
    output logic [N_WAKE-1:0]      wake_src_o = '0
);
    // ==========================================================
    // Firmware runs from the 24 MHz source before any low mode
    // Idle write is padded by a multi-byte instruction, so only
    // one completion pulse is issued per request
    always @(posedge clk_i)
    begin
        instr_done_o  <= step_i && !instr_done_o;
        irq_pending_o <= irq_i;
        wake_src_o    <= wake_i;
    end
endmodule

// >>> dv/tb_top.sv
// Self-checking bench for the power mode controller
`timescale 1ns/100ps
module tb_top
    import pmc_pkg::*;
;
    // ==========================================================
    localparam logic [7:0] PW_NORM = 8'hF8;
    localparam logic [7:0] PW_IDLE = 8'h78;
    localparam logic [7:0] PW_SUSP = 8'h08;
    localparam logic [7:0] PW_SNZ  = 8'h0C;
    logic              clk_i;
    logic              reset_n_i;
    logic              pin_n;
    logic              wdog;
    logic              mclk;
    logic              step;
    logic              irq;
    logic [N_WAKE-1:0] wake;
    logic              done;
    logic              pend;
    logic [N_WAKE-1:0] wsrc;
    logic [7:0]        awaddr;
    logic [7:0]        araddr;
    logic              awvalid;
    logic              wvalid;
    logic              bready;
    logic              arvalid;
    logic              rready;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic              arready;
    logic              rvalid;
    logic [1:0]        bresp;
    logic [1:0]        rresp;
    logic [31:0]       wdata;
    logic [31:0]       rdata;
    logic [31:0]       rd_data;
    logic [1:0]        rd_resp;
    power_ctl_s        power;
    logic              core_reset;
    logic [15:0]       fetch_addr;
    logic              fetch_load;
    logic              svc;
    mode_e             mode;
    int                bad_count;
    int                samples_checked;
    int                svc_cnt;
    int                fetch_cnt;
    int                s0;
    int                f0;

    cpu_model cpu (.clk_i(clk_i), .step_i(step), .irq_i(irq),
        .wake_i(wake), .instr_done_o(done), .irq_pending_o(pend),
        .wake_src_o(wsrc));

    power_mode_controller dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
        .reset_pin_n_i(pin_n), .watchdog_reset_i(wdog),
        .missing_clock_reset_i(mclk), .instr_done_i(done),
        .irq_pending_i(pend), .wake_src_i(wsrc),
        .s_awaddr_i(awaddr), .s_awvalid_i(awvalid),
        .s_awready_o(awready), .s_wdata_i(wdata),
        .s_wstrb_i(4'hF), .s_wvalid_i(wvalid), .s_wready_o(wready),
        .s_bresp_o(bresp), .s_bvalid_o(bvalid), .s_bready_i(bready),
        .s_araddr_i(araddr), .s_arvalid_i(arvalid),
        .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp),
        .s_rvalid_o(rvalid), .s_rready_i(rready), .power_o(power),
        .core_reset_o(core_reset), .fetch_addr_o(fetch_addr),
        .fetch_load_o(fetch_load), .irq_service_o(svc),
        .mode_o(mode));

    // ==========================================================
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // Pulses are counted so a missed or doubled one shows up
    always @(posedge clk_i)
    begin
        if (svc === 1'b1) svc_cnt++;
        if (fetch_load === 1'b1 && fetch_addr === RESET_PC) fetch_cnt++;
    end
    initial
    begin
        repeat (3000) @(posedge clk_i);
        bad_count++;
        finish_test();
    end

    // ==========================================================
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            bad_count++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
    endtask
    // Ready levels are read mid-cycle, as the next rising edge sees them
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic aw_t;
        logic w_t;
        logic b_t;
        @(posedge clk_i);
        {awaddr, wdata} <= {a, d};
        {awvalid, wvalid, bready} <= 3'b111;
        do
        begin
            @(negedge clk_i);
            {aw_t, w_t, b_t} = {awready, wready, bvalid === 1'b1};
            @(posedge clk_i);
            if (aw_t) awvalid <= 1'b0;
            if (w_t) wvalid <= 1'b0;
        end
        while (!b_t);
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        logic ar_t;
        logic r_t;
        @(posedge clk_i);
        araddr <= a;
        {arvalid, rready} <= 2'b11;
        do
        begin
            @(negedge clk_i);
            {ar_t, r_t} = {arready, rvalid === 1'b1};
            {rd_data, rd_resp} = {rdata, rresp};
            @(posedge clk_i);
            if (ar_t) arvalid <= 1'b0;
        end
        while (!r_t);
        rready <= 1'b0;
    endtask
    task automatic fire();
        @(posedge clk_i);
        step <= 1'b1;
        @(posedge clk_i);
        step <= 1'b0;
        s0 = svc_cnt;
        f0 = fetch_cnt;
        settle();
    endtask
    // Bit 2 pin, bit 1 watchdog, bit 0 missing clock
    task automatic src(input logic [2:0] s);
        @(posedge clk_i);
        {pin_n, wdog, mclk} <= {~s[2], s[1:0]};
        @(posedge clk_i);
        {pin_n, wdog, mclk} <= 3'b100;
        settle();
    endtask
    task automatic drive(input logic i, input logic [N_WAKE-1:0] w);
        @(posedge clk_i);
        irq <= i;
        wake <= w;
        settle();
    endtask

    // ==========================================================
    task automatic t_reset();
        settle();
        chk(power, PW_NORM);
        rd(WAKEN_OFS);
        chk(rd_data, 32'h0000_003F);
        rd(8'h14);
        chk({rd_data, rd_resp}, {ZERO32, RESP_SLVERR});
    endtask
    task automatic t_idle();
        wr(PCTL_OFS, 32'h0000_0001);
        fire();
        chk(mode, M_IDLE);
        chk(power, PW_IDLE);
        rd(PCTL_OFS);
        chk(rd_data, ZERO32);
        drive(1'b1, '0);
        chk(mode, M_NORMAL);
        chk({svc_cnt - s0, fetch_cnt - f0}, {32'd1, 32'd0});
        drive(1'b0, '0);
        wr(PCTL_OFS, 32'h0000_0001);
        fire();
        src(3'b010);
        chk(mode, M_NORMAL);
        chk(fetch_cnt - f0, 1);
    endtask
    task automatic t_stop();
        wr(PCTL_OFS, 32'h0000_0002);
        fire();
        chk({mode, power.core_clk_en, power.periph_clk_en}, {M_STOP, 2'b00});
        drive(1'b1, 6'h3F);
        chk(mode, M_STOP);
        drive(1'b0, '0);
        src(3'b001);
        chk(mode, M_NORMAL);
        chk(fetch_cnt - f0, 1);
    endtask
    task automatic t_suspend();
        for (int i = 0; i < N_WAKE; i++)
        begin
            wr(PCTLX_OFS, 32'h0000_0040);
            fire();
            chk({mode, power}, {M_SUSPEND, PW_SUSP});
            drive(1'b0, 6'h01 << i);
            chk(mode, M_NORMAL);
            chk(fetch_cnt - f0, 0);
            drive(1'b0, '0);
        end
        wr(WAKEN_OFS, 32'h0000_003E);
        wr(PCTLX_OFS, 32'h0000_0040);
        fire();
        drive(1'b0, 6'h01);
        chk(mode, M_SUSPEND);
        drive(1'b0, 6'h02);
        chk(mode, M_NORMAL);
        drive(1'b0, '0);
        wr(WAKEN_OFS, 32'h0000_003F);
    endtask
    task automatic t_snooze();
        wr(PCTLX_OFS, 32'h0000_0080);
        fire();
        chk({mode, power}, {M_SNOOZE, PW_SNZ});
        drive(1'b1, 6'h10);
        chk({mode, power}, {M_NORMAL, PW_NORM});
        chk(svc_cnt - s0, 1);
        drive(1'b0, '0);
    endtask
    task automatic t_shutdown();
        wr(REGCTL_OFS, 32'h0000_0008);
        wr(PCTL_OFS, 32'h0000_0002);
        fire();
        chk(mode, M_SHUTDOWN);
        chk({power.core_clk_en, power.ldo_off, power.io_hold}, 3'b011);
        src(3'b011);
        chk(mode, M_SHUTDOWN);
        src(3'b100);
        chk({mode, fetch_cnt - f0}, {M_NORMAL, 32'd1});
    endtask
    task automatic finish_test();
        $display("compared %0d mismatched %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // ==========================================================
    initial
    begin
        {reset_n_i, pin_n, wdog, mclk, step, irq} = 6'b010000;
        {awvalid, wvalid, bready, arvalid, rready} = 5'b00000;
        {awaddr, araddr, wdata, wake} = '0;
        {bad_count, samples_checked, svc_cnt, fetch_cnt} = '0;
        repeat (3) @(posedge clk_i);
        reset_n_i <= 1'b1;
        t_reset();
        t_idle();
        t_stop();
        t_suspend();
        t_snooze();
        t_shutdown();
        finish_test();
    end
endmodule

// >>> inc/pmc_pkg.sv
// Package: register map, fields and types of the power mode controller
package pmc_pkg;
    // ==========================================================
    // Register byte offsets (own choice of map)
    localparam logic [7:0] PCTL_OFS   = 8'h00;
    localparam logic [7:0] PCTLX_OFS  = 8'h04;
    localparam logic [7:0] REGCTL_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS   = 8'h0C;
    localparam logic [7:0] WAKEN_OFS  = 8'h10;
    // ==========================================================
    // Field positions
    localparam int IDLE_BIT    = 0;
    localparam int STOP_BIT    = 1;
    localparam int GF_LSB      = 2;
    localparam int SUSPEND_BIT = 6;
    localparam int SNOOZE_BIT  = 7;
    localparam int STOP_CONFIG_BIT_POS  = 3;
    localparam int N_WAKE      = 6;
    // ==========================================================
    // Reset values and misc constants
    localparam logic [31:0] ZERO32     = 32'h0000_0000;
    localparam logic [15:0] RESET_PC   = 16'h0000;
    localparam logic [1:0]  RESP_OKAY  = 2'b00;
    localparam logic [1:0]  RESP_SLVERR = 2'b10;
    localparam logic [5:0]  WAKEN_RST  = 6'h3F;
    // ==========================================================
    typedef enum logic [2:0] {
        M_NORMAL, M_IDLE, M_STOP, M_SUSPEND, M_SNOOZE, M_SHUTDOWN
    } mode_e;
    typedef struct packed {
        logic core_clk_en;
        logic periph_clk_en;
        logic hf_osc_24m_en;
        logic hf_osc_48m_en;
        logic lf_osc_80k_en;
        logic ldo_standby;
        logic ldo_off;
        logic io_hold;
    } power_ctl_s;
endpackage

// >>> src/power_mode_controller.sv
// Power mode controller with AXI4-Lite register slave
//
// The register offsets and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
// How it works
// - Idle request halts core, clocks keep running
// - Peripherals keep clock during idle
// - Enabled interrupt clears idle, core resumes
// - Resume after idle continues at next instruction
// - Reset ends low modes, fetch from zero
// - Watchdog reset terminates idle
// - Stop halts core, peripheral clocks and both fast oscillators
// - Stop left only by reset
// - Missing-clock reset ends stop
// - Suspend/snooze halt both fast oscillators
// - Suspend ends on enabled wake or reset
// - Six wake sources for suspend and snooze
// - Low-frequency oscillator keeps timers 3, 4 running
// - Snooze puts core regulator in standby
// - Snooze wake restores regulator and resumes in the same cycle
// - Wake interrupt serviced upon waking
// - Shutdown via stop-config then stop request
// - Shutdown powers nets off, pins hold
// - Idle and stop bits read zero
// - Stop-config set shuts regulator at stop
module power_mode_controller
    import pmc_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              reset_n_i,
    // Reset sources
    input  wire logic              reset_pin_n_i,
    input  wire logic              watchdog_reset_i,
    input  wire logic              missing_clock_reset_i,
    // Core handshake
    input  wire logic              instr_done_i,
    input  wire logic              irq_pending_i,
    input  wire logic [N_WAKE-1:0] wake_src_i,
    // AXI4-Lite slave
    input  wire logic [7:0]        s_awaddr_i,
    input  wire logic              s_awvalid_i,
    output logic                   s_awready_o,
    input  wire logic [31:0]       s_wdata_i,
    input  wire logic [3:0]        s_wstrb_i,
    input  wire logic              s_wvalid_i,
    output logic                   s_wready_o,
    output logic [1:0]             s_bresp_o,
    output logic                   s_bvalid_o,
    input  wire logic              s_bready_i,
    input  wire logic [7:0]        s_araddr_i,
    input  wire logic              s_arvalid_i,
    output logic                   s_arready_o,
    output logic [31:0]            s_rdata_o,
    output logic [1:0]             s_rresp_o,
    output logic                   s_rvalid_o,
    input  wire logic              s_rready_i,
    // Power control outputs
    output power_ctl_s             power_o,
    output logic                   core_reset_o,
    output logic [15:0]            fetch_addr_o,
    output logic                   fetch_load_o,
    output logic                   irq_service_o,
    output mode_e                  mode_o
);
    // ==========================================================
    // Registers
    mode_e      mode;
    mode_e      next_mode;
    logic [5:0] gp_flags;
    logic       stop_cfg;
    logic [N_WAKE-1:0] wake_en;
    logic       req_idle;
    logic       req_stop;
    logic       req_susp;
    logic       req_snooze;
    logic       aw_hold;
    logic       w_hold;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    // ==========================================================
    // Decode
    wire any_reset   = !reset_pin_n_i || watchdog_reset_i
                       || missing_clock_reset_i;
    wire pin_reset   = !reset_pin_n_i;
    wire wake_hit    = |(wake_src_i & wake_en);
    wire aw_ok       = aw_hold || s_awvalid_i;
    wire w_ok        = w_hold || s_wvalid_i;
    wire wr_fire     = aw_ok && w_ok && !s_bvalid_o;
    wire [7:0]  wa   = aw_hold ? aw_addr : s_awaddr_i;
    wire [31:0] wd   = w_hold ? w_data : s_wdata_i;
    wire        wb0  = w_hold ? w_strb[0] : s_wstrb_i[0];
    wire wr_pctl     = wr_fire && wb0 && wa == PCTL_OFS;
    wire wr_pctlx    = wr_fire && wb0 && wa == PCTLX_OFS;
    wire wr_regctl   = wr_fire && wb0 && wa == REGCTL_OFS;
    wire wr_waken    = wr_fire && wb0 && wa == WAKEN_OFS;
    wire wr_mapped   = wa == PCTL_OFS || wa == PCTLX_OFS
                       || wa == REGCTL_OFS || wa == WAKEN_OFS
                       || wa == STAT_OFS;
    wire rd_fire     = s_arvalid_i && s_arready_o;
    wire [31:0] rd_pctl   = {24'h00_0000, gp_flags, 2'b00};
    wire [31:0] rd_pctlx  = {24'h00_0000, req_snooze, req_susp, 6'h00};
    wire [31:0] rd_regctl = {28'h000_0000, stop_cfg, 3'h0};
    wire [31:0] rd_stat   = {29'h0000_0000, mode};
    wire [31:0] rd_waken  = {26'h000_0000, wake_en};
    wire [31:0] rd_mux =
        s_araddr_i == PCTL_OFS   ? rd_pctl   :
        s_araddr_i == PCTLX_OFS  ? rd_pctlx  :
        s_araddr_i == REGCTL_OFS ? rd_regctl :
        s_araddr_i == STAT_OFS   ? rd_stat   :
        s_araddr_i == WAKEN_OFS  ? rd_waken  : ZERO32;
    wire rd_mapped = s_araddr_i == PCTL_OFS || s_araddr_i == PCTLX_OFS
                     || s_araddr_i == REGCTL_OFS || s_araddr_i == STAT_OFS
                     || s_araddr_i == WAKEN_OFS;
    // ==========================================================
    // AXI write channel
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            aw_hold    <= 1'b0;
            w_hold     <= 1'b0;
            aw_addr    <= 8'h00;
            w_data     <= ZERO32;
            w_strb     <= 4'h0;
            s_bvalid_o <= 1'b0;
            s_bresp_o  <= RESP_OKAY;
        end
        else
        begin
            if (s_awvalid_i && s_awready_o && !wr_fire)
            begin
                aw_hold <= 1'b1;
                aw_addr <= s_awaddr_i;
            end
            if (s_wvalid_i && s_wready_o && !wr_fire)
            begin
                w_hold <= 1'b1;
                w_data <= s_wdata_i;
                w_strb <= s_wstrb_i;
            end
            if (wr_fire)
            begin
                aw_hold    <= 1'b0;
                w_hold     <= 1'b0;
                s_bvalid_o <= 1'b1;
                s_bresp_o  <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
            end
            else if (s_bready_i)
                s_bvalid_o <= 1'b0;
        end
    end
    assign s_awready_o = !aw_hold && !s_bvalid_o;
    assign s_wready_o  = !w_hold && !s_bvalid_o;
    // ==========================================================
    // AXI read channel
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            s_rvalid_o <= 1'b0;
            s_rdata_o  <= ZERO32;
            s_rresp_o  <= RESP_OKAY;
        end
        else if (rd_fire)
        begin
            s_rvalid_o <= 1'b1;
            s_rdata_o  <= rd_mux;
            s_rresp_o  <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_rready_i)
            s_rvalid_o <= 1'b0;
    end
    assign s_arready_o = !s_rvalid_o;
    // ==========================================================
    // Control registers; requests latch until the instruction ends
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || any_reset)
        begin
            gp_flags   <= 6'h00;
            stop_cfg   <= 1'b0;
            wake_en    <= WAKEN_RST;
            req_idle   <= 1'b0;
            req_stop   <= 1'b0;
            req_susp   <= 1'b0;
            req_snooze <= 1'b0;
        end
        else
        begin
            if (wr_pctl)
            begin
                gp_flags <= wd[GF_LSB +: 6];
                req_idle <= req_idle | wd[IDLE_BIT];
                req_stop <= req_stop | wd[STOP_BIT];
            end
            if (wr_pctlx)
            begin
                req_susp   <= req_susp | wd[SUSPEND_BIT];
                req_snooze <= req_snooze | wd[SNOOZE_BIT];
            end
            if (wr_regctl)
                stop_cfg <= wd[STOP_CONFIG_BIT_POS];
            if (wr_waken)
                wake_en <= wd[N_WAKE-1:0];
            if (mode == M_IDLE && irq_pending_i)
                req_idle <= 1'b0;
            if (instr_done_i && mode == M_NORMAL)
            begin
                req_stop <= 1'b0;
                if (req_susp || req_snooze || req_stop)
                    req_idle <= 1'b0;
            end
            if ((mode == M_SUSPEND || mode == M_SNOOZE) && wake_hit)
            begin
                req_susp   <= 1'b0;
                req_snooze <= 1'b0;
            end
        end
    end
    // ==========================================================
    // Mode sequencer
    always_comb
    begin
        next_mode = mode;
        case (mode)
            M_NORMAL:
                if (instr_done_i)
                begin
                    if (req_stop && stop_cfg)
                        next_mode = M_SHUTDOWN;
                    else if (req_stop)
                        next_mode = M_STOP;
                    else if (req_snooze)
                        next_mode = M_SNOOZE;
                    else if (req_susp)
                        next_mode = M_SUSPEND;
                    else if (req_idle)
                        next_mode = M_IDLE;
                end
            M_IDLE:
                if (irq_pending_i)
                    next_mode = M_NORMAL;
            M_STOP:
                next_mode = M_STOP;
            M_SUSPEND, M_SNOOZE:
                if (wake_hit)
                    next_mode = M_NORMAL;
            M_SHUTDOWN:
                next_mode = M_SHUTDOWN;
            default:
                next_mode = M_NORMAL;
        endcase
    end
    // Shutdown honours only the pin; other modes any reset source
    wire mode_reset = (mode == M_SHUTDOWN) ? pin_reset : any_reset;
    // Outputs follow the mode that is really taken, reset included
    mode_e next_eff;
    assign next_eff = mode_reset ? M_NORMAL : next_mode;
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i || mode_reset)
            mode <= M_NORMAL;
        else
            mode <= next_mode;
    end
    // ==========================================================
    // Outputs
    always_ff @(posedge clk_i)
    begin
        if (!reset_n_i)
        begin
            power_o       <= '0;
            core_reset_o  <= 1'b1;
            fetch_addr_o  <= RESET_PC;
            fetch_load_o  <= 1'b0;
            irq_service_o <= 1'b0;
            mode_o        <= M_NORMAL;
        end
        else
        begin
            mode_o                <= next_eff;
            power_o.core_clk_en   <= next_eff == M_NORMAL;
            power_o.periph_clk_en <= next_eff inside {M_NORMAL, M_IDLE};
            power_o.hf_osc_24m_en <= next_eff inside {M_NORMAL, M_IDLE};
            power_o.hf_osc_48m_en <= next_eff inside {M_NORMAL, M_IDLE};
            power_o.lf_osc_80k_en <= next_eff != M_SHUTDOWN;
            power_o.ldo_standby   <= next_eff == M_SNOOZE;
            power_o.ldo_off       <= next_eff == M_SHUTDOWN;
            power_o.io_hold       <= next_eff == M_SHUTDOWN;
            core_reset_o  <= mode_reset;
            fetch_load_o  <= mode_reset;
            fetch_addr_o  <= RESET_PC;
            irq_service_o <= !mode_reset && irq_pending_i
                && next_mode == M_NORMAL && mode != M_NORMAL;
        end
    end
    // ==========================================================
    // Assertions
    property p_idle_halt;
        @(posedge clk_i) disable iff (!reset_n_i)
        mode == M_IDLE |-> !power_o.core_clk_en && power_o.periph_clk_en;
    endproperty
    a_idle_halt: assert property (p_idle_halt) else $error("idle clocks");
    property p_idle_wake;
        @(posedge clk_i) disable iff (!reset_n_i)
        mode == M_IDLE && irq_pending_i && !any_reset
            |=> mode == M_NORMAL && !req_idle;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("idle wake");
    property p_stop_stays;
        @(posedge clk_i) disable iff (!reset_n_i)
        mode == M_STOP && !any_reset |=> mode == M_STOP;
    endproperty
    a_stop_stays: assert property (p_stop_stays) else $error("stop left");
    property p_reset_fetch;
        @(posedge clk_i) disable iff (!reset_n_i)
        mode != M_SHUTDOWN && any_reset
            |=> fetch_load_o && fetch_addr_o == RESET_PC ##1 mode_o == M_NORMAL;
    endproperty
    a_reset_fetch: assert property (p_reset_fetch) else $error("reset");
    property p_snooze_ldo;
        @(posedge clk_i) disable iff (!reset_n_i)
        mode == M_SNOOZE |-> power_o.ldo_standby && !power_o.hf_osc_24m_en;
    endproperty
    a_snooze_ldo: assert property (p_snooze_ldo) else $error("snooze ldo");
    property p_wake;
        @(posedge clk_i) disable iff (!reset_n_i)
        (mode == M_SUSPEND || mode == M_SNOOZE) && wake_hit && !any_reset
            |=> mode == M_NORMAL ##0 !power_o.ldo_standby;
    endproperty
    a_wake: assert property (p_wake) else $error("wake");
    property p_shutdown;
        @(posedge clk_i) disable iff (!reset_n_i)
        mode == M_SHUTDOWN && !pin_reset
            |=> mode == M_SHUTDOWN && power_o.ldo_off && power_o.io_hold;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown");
    property p_stop_config_bit;
        @(posedge clk_i) disable iff (!reset_n_i)
        mode == M_NORMAL && instr_done_i && req_stop && stop_cfg && !any_reset
            |=> mode == M_SHUTDOWN;
    endproperty
    a_stop_config_bit: assert property (p_stop_config_bit) else $error("stop cfg");
    property p_read_zero;
        @(posedge clk_i) disable iff (!reset_n_i)
        s_rvalid_o && $rose(s_rvalid_o) && s_rresp_o == RESP_OKAY
            && $past(s_araddr_i) == PCTL_OFS |-> s_rdata_o[1:0] == 2'b00;
    endproperty
    a_read_zero: assert property (p_read_zero) else $error("req read");
    c_idle: cover property (@(posedge clk_i) mode == M_IDLE ##1 mode == M_NORMAL);
    c_snooze: cover property (@(posedge clk_i) mode == M_SNOOZE ##1 mode == M_NORMAL);
    c_shut: cover property (@(posedge clk_i) mode == M_SHUTDOWN);
endmodule
